/* File: logic/bcp_port.sv */
// bus control port: three-bit control port and high-byte port with bus takeover
// What this block does
// RL1 - control pin is an input while its direction bit is one
// RL2 - control pin drives its latch bit while direction bit is zero
// RL3 - data read returns pin levels; data write changes only the latch
// RL4 - microprocessor or extended modes hand the control port to the bus
// RL5 - bit 0 is general I/O or the address latch strobe
// RL6 - bit 1 is general I/O or the active-low read strobe
// RL7 - bit 2 is general I/O or the active-low write strobe
// RL8 - read and write strobes are active low on both sides
// RL9 - other two microcontroller modes keep the port as plain I/O
// RL10 - every reset sets control direction to ones; latch kept on soft reset
// RL11 - every reset sets high-byte direction to ones; latch kept on soft reset
// RL12 - upper five bits of the control registers read as zero
// RL13 - a write stores the whole latch, input bits included
// RL14 - write lands at cycle end, read samples pins at cycle start
// RL15 - software leaves one instruction between write and read of a port
// RL16 - outside parties do not fight a pin the device drives
// RL17 - master clear and watchdog resets keep the data latches
// RL18 - in bus modes the high-byte port carries address/data bits 15:8
// RL19 - high-byte pin is input when its direction bit is one, else output
// RL20 - while serving the bus, bus logic owns direction and drive
`timescale 1ns/100ps
module bcp_port
(
	input  wire logic       core_clk,                 // 100 MHz instruction clock
	input  wire logic       rstn,                     // power-on reset, active low
	input  wire logic       nonpor_rst,               // master clear or watchdog reset
	input  wire logic [1:0] op_mode,                  // operating mode configuration
	input  wire logic [3:0] bank_select_reg,          // current register bank
	input  wire logic [7:0] reg_addr,                 // register offset
	input  wire logic       reg_wr,                   // register write strobe
	input  wire logic       reg_rd,                   // register read strobe
	input  wire logic [7:0] reg_wdata,                // write data
	output logic      [7:0] reg_rdata,                // read data, registered
	input  wire logic       bus_ale,                  // address latch strobe from bus logic
	input  wire logic       bus_oe_n,                 // read strobe from bus logic, low active
	input  wire logic       bus_wr_n,                 // write strobe from bus logic, low active
	input  wire logic [7:0] bus_hi_out,               // high address/data byte to drive
	input  wire logic       bus_hi_drive,             // bus logic drives the high byte
	output logic      [7:0] bus_hi_in,                // high byte sampled from pins
	output logic            bus_mode,                 // port is serving the bus
	input  wire logic       addr_latch_strobe_pin_in, // pin 0 level
	output logic            addr_latch_strobe_pin_out,// pin 0 drive value
	output logic            addr_latch_strobe_pin_oe, // pin 0 drive enable
	input  wire logic       read_strobe_n_pin_in,     // pin 1 level
	output logic            read_strobe_n_pin_out,    // pin 1 drive value
	output logic            read_strobe_n_pin_oe,     // pin 1 drive enable
	input  wire logic       write_strobe_n_pin_in,    // pin 2 level
	output logic            write_strobe_n_pin_out,   // pin 2 drive value
	output logic            write_strobe_n_pin_oe,    // pin 2 drive enable
	input  wire logic [7:0] muxed_addr_data_high_in,  // high-byte pin levels
	output logic      [7:0] muxed_addr_data_high_out, // high-byte drive values
	output logic      [7:0] muxed_addr_data_high_oe   // high-byte drive enables
);

	// bus takeover decode, used by both ports
	function automatic logic is_bus_mode(input logic [1:0] mode);
		is_bus_mode = (mode == bcp_pkg::MODE_MICROPROC) || (mode == bcp_pkg::MODE_EXT_MCU);
	endfunction

	logic       rst_meta_r;
	logic       rst_n;
	logic [2:0] ctl_dir_r;
	logic [2:0] ctl_latch_r;
	logic [7:0] hi_dir_r;
	logic [7:0] hi_latch_r;
	logic [2:0] ctl_pin_lvl;
	logic [2:0] ctl_bus_val;
	logic [2:0] ctl_out;
	logic [2:0] ctl_oe;
	logic       bus_now;
	logic       bank_hit;
	logic       wr_ctl_dir;
	logic       wr_ctl_data;
	logic       wr_hi_dir;
	logic       wr_hi_data;
	logic [7:0] rd_nxt;

	// reset release through two flops; the first is seen only by the second
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_meta_r <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n      <= rst_meta_r;
		end
	end

	// access decode; only the port bank reaches these offsets
	assign bank_hit    = (bank_select_reg == bcp_pkg::PORT_BANK);
	assign wr_ctl_dir  = reg_wr && bank_hit && (reg_addr == bcp_pkg::OFS_CTL_DIR);
	assign wr_ctl_data = reg_wr && bank_hit && (reg_addr == bcp_pkg::OFS_CTL_DATA);
	assign wr_hi_dir   = reg_wr && bank_hit && (reg_addr == bcp_pkg::OFS_HI_DIR);
	assign wr_hi_data  = reg_wr && bank_hit && (reg_addr == bcp_pkg::OFS_HI_DATA);
	assign bus_now     = is_bus_mode(op_mode); // RL4 RL9

	// control direction: ones on any reset so pins come up as inputs
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			ctl_dir_r <= bcp_pkg::CTL_DIR_RST; // RL10
		else if (nonpor_rst)
			ctl_dir_r <= bcp_pkg::CTL_DIR_RST; // RL10 RL17
		else if (wr_ctl_dir)
			ctl_dir_r <= reg_wdata[bcp_pkg::CTL_W-1:0];
	end

	// control latch: whole field written, input bits too, so rmw copies pin levels
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			ctl_latch_r <= bcp_pkg::CTL_LATCH_POR;
		else if (wr_ctl_data && !nonpor_rst)
			ctl_latch_r <= reg_wdata[bcp_pkg::CTL_W-1:0]; // RL3 RL13 RL14 RL17
	end

	// high-byte direction: ones on any reset
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			hi_dir_r <= bcp_pkg::HI_DIR_RST; // RL11
		else if (nonpor_rst)
			hi_dir_r <= bcp_pkg::HI_DIR_RST; // RL11 RL17
		else if (wr_hi_dir)
			hi_dir_r <= reg_wdata;
	end

	// high-byte latch, kept across soft resets
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			hi_latch_r <= bcp_pkg::HI_LATCH_POR;
		else if (wr_hi_data && !nonpor_rst)
			hi_latch_r <= reg_wdata; // RL13 RL14 RL17
	end

	// pin levels and bus strobes packed by bit position
	assign ctl_pin_lvl = {write_strobe_n_pin_in, read_strobe_n_pin_in, addr_latch_strobe_pin_in};
	assign ctl_bus_val[bcp_pkg::ALE_BIT]  = bus_ale;  // RL5
	assign ctl_bus_val[bcp_pkg::OE_N_BIT] = bus_oe_n; // RL6 RL8
	assign ctl_bus_val[bcp_pkg::WR_N_BIT] = bus_wr_n; // RL7 RL8

	// per-pin mux: bus strobes always driven in bus mode, else latch under direction
	genvar gi;
	generate
		for (gi = 0; gi < bcp_pkg::CTL_W; gi++)
		begin : g_ctl
			assign ctl_out[gi] = bus_now ? ctl_bus_val[gi] : ctl_latch_r[gi]; // RL2 RL20
			assign ctl_oe[gi]  = bus_now ? 1'b1 : ~ctl_dir_r[gi]; // RL1 RL2 RL20
		end
		for (gi = 0; gi < bcp_pkg::HI_W; gi++)
		begin : g_hi
			assign muxed_addr_data_high_out[gi] = bus_now ? bus_hi_out[gi] : hi_latch_r[gi]; // RL18
			assign muxed_addr_data_high_oe[gi]  = bus_now ? bus_hi_drive : ~hi_dir_r[gi]; // RL19 RL20
		end
	endgenerate

	assign addr_latch_strobe_pin_out = ctl_out[bcp_pkg::ALE_BIT];
	assign addr_latch_strobe_pin_oe  = ctl_oe[bcp_pkg::ALE_BIT];
	assign read_strobe_n_pin_out     = ctl_out[bcp_pkg::OE_N_BIT];
	assign read_strobe_n_pin_oe      = ctl_oe[bcp_pkg::OE_N_BIT];
	assign write_strobe_n_pin_out    = ctl_out[bcp_pkg::WR_N_BIT];
	assign write_strobe_n_pin_oe     = ctl_oe[bcp_pkg::WR_N_BIT];

	// read mux; data registers return pin levels, not latches
	always_comb
	begin
		rd_nxt = bcp_pkg::UNMAPPED_RD;
		if (bank_hit)
		begin
			unique case (reg_addr)
				bcp_pkg::OFS_HI_DIR:   rd_nxt = hi_dir_r;
				bcp_pkg::OFS_HI_DATA:  rd_nxt = muxed_addr_data_high_in; // RL3
				bcp_pkg::OFS_CTL_DIR:  rd_nxt = {{bcp_pkg::CTL_PAD_W{1'b0}}, ctl_dir_r}; // RL12
				bcp_pkg::OFS_CTL_DATA: rd_nxt = {{bcp_pkg::CTL_PAD_W{1'b0}}, ctl_pin_lvl}; // RL3 RL12
				default:               rd_nxt = bcp_pkg::UNMAPPED_RD;
			endcase
		end
	end

	// read data sampled on the edge that opens the cycle; a write in the same
	// cycle shows on the pins only afterwards, hence the gap software leaves
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= bcp_pkg::RDATA_RST;
		else if (reg_rd)
			reg_rdata <= rd_nxt; // RL14 RL15
	end

	// bus-side sample of the high byte and registered mode flag
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bus_hi_in <= bcp_pkg::HI_LATCH_POR;
			bus_mode  <= 1'b0;
		end
		else
		begin
			bus_hi_in <= muxed_addr_data_high_in; // RL18
			bus_mode  <= bus_now;
		end
	end

	// checks
	sequence s_ctl_data_rd;
		reg_rd && bank_hit && (reg_addr == bcp_pkg::OFS_CTL_DATA);
	endsequence

	sequence s_ctl_data_wr;
		wr_ctl_data && !nonpor_rst;
	endsequence

	sequence s_soft_reset;
		nonpor_rst;
	endsequence

	a_dir_input_off: assert property (@(posedge core_clk) disable iff (!rst_n) // RL1
		!bus_now |-> ((ctl_oe & ctl_dir_r) == 3'h0))
		else $error("control pin driven while direction says input");

	a_dir_output_drv: assert property (@(posedge core_clk) disable iff (!rst_n) // RL2
		!bus_now |-> ((ctl_oe == ~ctl_dir_r) && ((ctl_out & ~ctl_dir_r) == (ctl_latch_r & ~ctl_dir_r))))
		else $error("output pin not driven from latch");

	a_read_pins: assert property (@(posedge core_clk) disable iff (!rst_n) // RL3
		s_ctl_data_rd |=> (reg_rdata[2:0] == $past(ctl_pin_lvl)))
		else $error("data read did not return pin levels");

	a_upper_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // RL12
		s_ctl_data_rd |=> (reg_rdata[7:3] == 5'h00))
		else $error("unimplemented bits read nonzero");

	a_bus_strobes: assert property (@(posedge core_clk) disable iff (!rst_n) // RL4
		bus_now |-> (ctl_oe == 3'h7) && (ctl_out == {bus_wr_n, bus_oe_n, bus_ale}))
		else $error("bus mode strobes not on control pins");

	a_gpio_modes: assert property (@(posedge core_clk) disable iff (!rst_n) // RL9
		((op_mode == bcp_pkg::MODE_MICROCTL) || (op_mode == bcp_pkg::MODE_PROT_MCU))
		|-> (ctl_out == ctl_latch_r))
		else $error("plain mode pins not following latch");

	a_soft_rst_keep: assert property (@(posedge core_clk) disable iff (!rst_n) // RL10
		s_soft_reset |=> (ctl_dir_r == 3'h7) && (hi_dir_r == 8'hFF)
		&& (ctl_latch_r == $past(ctl_latch_r)) && (hi_latch_r == $past(hi_latch_r)))
		else $error("soft reset directions or latch retention wrong");

	a_write_latch: assert property (@(posedge core_clk) disable iff (!rst_n) // RL13
		s_ctl_data_wr ##1 !bus_now |-> (ctl_latch_r == $past(reg_wdata[2:0]))
		&& (ctl_out == ctl_latch_r))
		else $error("write did not land in whole latch");

	a_hi_takeover: assert property (@(posedge core_clk) disable iff (!rst_n) // RL20
		bus_now |-> (muxed_addr_data_high_out == bus_hi_out)
		&& (muxed_addr_data_high_oe == {8{bus_hi_drive}}))
		else $error("bus does not own the high byte");

	a_hi_direction: assert property (@(posedge core_clk) disable iff (!rst_n) // RL19
		!bus_now |-> (muxed_addr_data_high_oe == ~hi_dir_r))
		else $error("high byte enable does not follow direction");

	sequence s_hi_data_rd;
		reg_rd && bank_hit && (reg_addr == bcp_pkg::OFS_HI_DATA);
	endsequence

	sequence s_ctl_dir_rd;
		reg_rd && bank_hit && (reg_addr == bcp_pkg::OFS_CTL_DIR);
	endsequence

	a_ale_strobe: assert property (@(posedge core_clk) disable iff (!rst_n) // RL5
		bus_now |-> addr_latch_strobe_pin_oe && (addr_latch_strobe_pin_out == bus_ale))
		else $error("address latch strobe not on pin 0");

	a_oe_strobe: assert property (@(posedge core_clk) disable iff (!rst_n) // RL6 RL8
		bus_now |-> read_strobe_n_pin_oe && (read_strobe_n_pin_out == bus_oe_n))
		else $error("read strobe not on pin 1 at its low active level");

	a_wr_strobe: assert property (@(posedge core_clk) disable iff (!rst_n) // RL7 RL8
		bus_now |-> write_strobe_n_pin_oe && (write_strobe_n_pin_out == bus_wr_n))
		else $error("write strobe not on pin 2 at its low active level");

	a_hi_read_pins: assert property (@(posedge core_clk) disable iff (!rst_n) // RL3
		s_hi_data_rd |=> (reg_rdata == $past(muxed_addr_data_high_in)))
		else $error("high byte read did not return pin levels");

	a_dir_read_pad: assert property (@(posedge core_clk) disable iff (!rst_n) // RL12
		s_ctl_dir_rd |=> (reg_rdata == {5'h00, $past(ctl_dir_r)}))
		else $error("control direction read not padded with zeros");

	a_hi_write_latch: assert property (@(posedge core_clk) disable iff (!rst_n) // RL13
		wr_hi_data && !nonpor_rst |=> (hi_latch_r == $past(reg_wdata)))
		else $error("high byte write did not land in whole latch");

	a_soft_data_drop: assert property (@(posedge core_clk) disable iff (!rst_n) // RL17
		nonpor_rst && (wr_ctl_data || wr_hi_data) |=> (ctl_latch_r == $past(ctl_latch_r))
		&& (hi_latch_r == $past(hi_latch_r)))
		else $error("data write changed a latch during soft reset");

	a_bus_hi_sample: assert property (@(posedge core_clk) disable iff (!rst_n) // RL18
		rst_n |=> (bus_hi_in == $past(muxed_addr_data_high_in)))
		else $error("bus side high byte not sampled from pins");

	a_hi_out_gpio: assert property (@(posedge core_clk) disable iff (!rst_n) // RL19
		!bus_now |-> (muxed_addr_data_high_out == hi_latch_r))
		else $error("high byte pins not driven from latch");

endmodule

/* File: logic/bcp_pkg.sv */
// constants shared by the bus control port and its users
package bcp_pkg;
	// register offsets within the port bank
	localparam logic [7:0] OFS_HI_DIR    = 8'h12;
	localparam logic [7:0] OFS_HI_DATA   = 8'h13;
	localparam logic [7:0] OFS_CTL_DIR   = 8'h14;
	localparam logic [7:0] OFS_CTL_DATA  = 8'h15;
	localparam logic [3:0] PORT_BANK     = 4'h1;
	// widths
	localparam int         CTL_W         = 3;
	localparam int         HI_W          = 8;
	localparam int         CTL_PAD_W     = 5;
	// control pin positions in the bus mode
	localparam int         ALE_BIT       = 0;
	localparam int         OE_N_BIT      = 1;
	localparam int         WR_N_BIT      = 2;
	// reset values
	localparam logic [2:0] CTL_DIR_RST   = 3'h7;
	localparam logic [7:0] HI_DIR_RST    = 8'hFF;
	localparam logic [2:0] CTL_LATCH_POR = 3'h0;
	localparam logic [7:0] HI_LATCH_POR  = 8'h00;
	localparam logic [7:0] RDATA_RST     = 8'h00;
	localparam logic [7:0] UNMAPPED_RD   = 8'h00;
	// operating mode codes on the configuration input
	localparam logic [1:0] MODE_MICROPROC = 2'h0;
	localparam logic [1:0] MODE_MICROCTL  = 2'h1;
	localparam logic [1:0] MODE_EXT_MCU   = 2'h2;
	localparam logic [1:0] MODE_PROT_MCU  = 2'h3;
endpackage

/* File: test/bcp_ext_model.sv */
// external memory and peripherals seen at the control and high-byte pins
`timescale 1ns/100ps
module bcp_ext_model
(
	input  wire logic [2:0] ctl_out, // device drive values, control pins
	input  wire logic [2:0] ctl_oe,  // device drive enables, control pins
	input  wire logic [2:0] ctl_ext, // level the far side offers on free pins
	output logic      [2:0] ctl_pin, // resolved control pin levels
	input  wire logic [7:0] hi_out,  // device drive values, high byte
	input  wire logic [7:0] hi_oe,   // device drive enables, high byte
	input  wire logic [7:0] hi_ext,  // level the far side offers on free pins
	output logic      [7:0] hi_pin,  // resolved high-byte pin levels
	output logic            rd_act,  // far side sees a read strobe
	output logic            wr_act   // far side sees a write strobe
);
	// far side drives only released pins, so it never fights a driven one
	assign ctl_pin = (ctl_oe & ctl_out) | (~ctl_oe & ctl_ext);
	assign hi_pin  = (hi_oe & hi_out) | (~hi_oe & hi_ext);
	// strobes count as active while low
	assign rd_act = ~ctl_pin[1];
	assign wr_act = ~ctl_pin[2];
endmodule

/* File: test/bcp_port_tb_top.sv */
// self-checking bench for the bus control port
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
	$display("Error %s expected %h seen %h", n, e, g); end end
module bcp_port_tb_top;
	logic       core_clk, rstn, nonpor_rst, reg_wr, reg_rd, bus_ale, bus_oe_n;
	logic       bus_wr_n, bus_hi_drive, bus_mode, rd_act, wr_act;
	logic [1:0] op_mode;
	logic [3:0] bank;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, bus_hi_out, bus_hi_in, d;
	logic [2:0] c_out, c_oe, c_ext, c_pin;
	logic [7:0] h_out, h_oe, h_ext, h_pin;
	int         err_total, num_checks;
	bcp_port u_bcp_port (.core_clk(core_clk), .rstn(rstn), .nonpor_rst(nonpor_rst),
		.op_mode(op_mode), .bank_select_reg(bank), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .bus_ale(bus_ale),
		.bus_oe_n(bus_oe_n), .bus_wr_n(bus_wr_n), .bus_hi_out(bus_hi_out),
		.bus_hi_drive(bus_hi_drive), .bus_hi_in(bus_hi_in), .bus_mode(bus_mode),
		.addr_latch_strobe_pin_in(c_pin[0]), .addr_latch_strobe_pin_out(c_out[0]),
		.addr_latch_strobe_pin_oe(c_oe[0]), .read_strobe_n_pin_in(c_pin[1]),
		.read_strobe_n_pin_out(c_out[1]), .read_strobe_n_pin_oe(c_oe[1]),
		.write_strobe_n_pin_in(c_pin[2]), .write_strobe_n_pin_out(c_out[2]),
		.write_strobe_n_pin_oe(c_oe[2]), .muxed_addr_data_high_in(h_pin),
		.muxed_addr_data_high_out(h_out), .muxed_addr_data_high_oe(h_oe));
	bcp_ext_model u_bcp_ext_model (.ctl_out(c_out), .ctl_oe(c_oe), .ctl_ext(c_ext),
		.ctl_pin(c_pin), .hi_out(h_out), .hi_oe(h_oe), .hi_ext(h_ext), .hi_pin(h_pin),
		.rd_act(rd_act), .wr_act(wr_act));
	// free-running 100 MHz clock
	always #5 core_clk = ~core_clk;
	// register write, taken at the edge after the request is raised
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	// register read, one idle edge after any write so pins have settled
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic t_reset;
		rd(8'h12, d); `CHK("hi dir", 8'hFF, d)
		rd(8'h14, d); `CHK("ctl dir", 8'h07, d)
		`CHK("ctl oe", 3'h0, c_oe)
		`CHK("hi oe", 8'h00, h_oe)
	endtask
	task automatic t_gpio;
		wr(8'h15, 8'h05); wr(8'h14, 8'h00);
		`CHK("ctl oe", 3'h7, c_oe)
		`CHK("ctl out", 3'h5, c_out)
		rd(8'h15, d); `CHK("ctl data", 8'h05, d)
		wr(8'h14, 8'h03);
		rd(8'h15, d); `CHK("ctl mixed", 8'h06, d)
		wr(8'h14, 8'hFF);
		rd(8'h14, d); `CHK("ctl dir pad", 8'h07, d)
	endtask
	// bit set on a port with all inputs: pin levels land in the whole latch
	task automatic t_rmw;
		rd(8'h15, d); `CHK("rmw read", 8'h02, d)
		wr(8'h15, d | 8'h04); wr(8'h14, 8'h00);
		`CHK("rmw latch", 3'h6, c_out)
	endtask
	task automatic t_soft;
		@(posedge core_clk);
		nonpor_rst <= 1'b1;
		reg_addr <= 8'h15;
		reg_wdata <= 8'h01;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		nonpor_rst <= 1'b0;
		reg_wr <= 1'b0;
		#1 `CHK("soft ctl oe", 3'h0, c_oe)
		wr(8'h14, 8'h00); `CHK("soft latch", 3'h6, c_out)
	endtask
	task automatic t_hi;
		wr(8'h13, 8'hA5); wr(8'h12, 8'h0F);
		`CHK("hi oe", 8'hF0, h_oe)
		`CHK("hi out", 8'hA5, h_out)
		rd(8'h13, d); `CHK("hi data", 8'hAA, d)
		bank <= 4'h0;
		wr(8'h13, 8'h00);
		bank <= 4'h1;
		rd(8'h13, d); `CHK("other bank", 8'hAA, d)
		rd(8'h16, d); `CHK("unmapped", 8'h00, d)
	endtask
	// both bus modes hand the pins to bus logic, the other two keep plain I/O
	task automatic t_bus;
		for (int m = 0; m < 4; m++)
		begin
			@(posedge core_clk);
			op_mode <= m[1:0];
			@(posedge core_clk);
			#1;
			if (m == 0 || m == 2)
			begin
				`CHK("bus ctl oe", 3'h7, c_oe)
				`CHK("bus strobes", 3'h5, c_out)
				`CHK("rd active", 1'b1, rd_act)
				`CHK("wr idle", 1'b0, wr_act)
				`CHK("bus hi oe", 8'hFF, h_oe)
				`CHK("bus hi out", 8'hC3, h_out)
				`CHK("bus hi in", 8'hC3, bus_hi_in)
				`CHK("bus mode", 1'b1, bus_mode)
			end
			else
			begin
				`CHK("io ctl out", 3'h6, c_out)
				`CHK("io hi oe", 8'hF0, h_oe)
				`CHK("io mode", 1'b0, bus_mode)
			end
		end
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// reset, then scenarios in order
	initial
	begin
		{core_clk, rstn, nonpor_rst, reg_wr, reg_rd} = 5'h00;
		{op_mode, bank, reg_addr, reg_wdata} = {2'h1, 4'h1, 8'h00, 8'h00};
		{bus_ale, bus_oe_n, bus_wr_n, bus_hi_drive} = 4'hB;
		{bus_hi_out, c_ext, h_ext} = {8'hC3, 3'h2, 8'h5A};
		err_total = 0;
		num_checks = 0;
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge core_clk);
		t_reset;
		t_gpio;
		t_rmw;
		t_soft;
		t_hi;
		t_bus;
		summarize;
	end
	// cut a hang short well past the expected run of under 200 cycles
	initial
	begin
		#20000;
		err_total++;
		summarize;
	end
endmodule
